/* src/flash_front_end_consts.svh */
/*
  Constants for the serial flash front end: address map fields and instruction
  codes. Assumes inclusion by its bare name.
*/
// Contract
// - Address space split into 4K/32K/64K units
// - Link works in clock mode 0 or 3
// - Sample on rising edge, drive after falling
// - Dual reads use two bidirectional lines
// - Quad reads use four bidirectional lines
// - Quad instructions need quad enable set
// - One mode at a time; enter/exit codes
// - Four-line mode: instruction in two clocks
// - Power-up and software reset give SPI mode
// - Four-line entry refused without quad enable
// - First operation needs select falling edge
// - Ignore instructions while power-on reset active
// - Active while selected, standby when idle
// - Pause keeps bit position of transfer
// - Paused: output released, inputs ignored
// - Select high while paused resets interface
// - Pause entry only with clock low
// - Pause exit only with clock low
// - Deselected: inputs ignored, outputs released
// - Quad enable disables guard and pause
// - Pause does not stop internal operations
`ifndef FLASH_FRONT_END_CONSTS_SVH
`define FLASH_FRONT_END_CONSTS_SVH
`define SECTOR_LSB 12
`define HALF_BLOCK_LSB 15
`define BLOCK_LSB 16
`define ADDR_BITS 24
`define CMD_DUAL_OUT 8'h3B
`define CMD_DUAL_IO 8'hBB
`define CMD_QUAD_OUT 8'h6B
`define CMD_QUAD_IO 8'hEB
`define CMD_QUAD_WORD 8'hE7
`define CMD_QUAD_OCTAL 8'hE3
`define CMD_ENTER_4L 8'h38
`define CMD_EXIT_4L 8'hFF
`define CMD_RESET_EN 8'h66
`define CMD_RESET 8'h99
`endif

/* src/flash_front_end_pkg.sv */
/*
  Types for the serial flash front end. Assumes nothing beyond the header.
*/
package flash_front_end_pkg;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b011,
    PH_DATA = 3'b010,
    PH_IDLE = 3'b110
  } phase_type;

  typedef enum logic [1:0] {
    W_ONE = 2'h0,
    W_TWO = 2'h1,
    W_FOUR = 2'h3
  } width_type;
endpackage : flash_front_end_pkg

/* src/serial_flash_bus_front_end.sv */
/*
  Serial front end of the flash: samples the host's serial clock, select
  and four data lines with clk_i, decodes instructions, tracks mode, pause
  and power state, and returns read data for the array behind it.
  Assumes the array answers rd_data_i combinationally from addr_o and that
  write_busy_i comes from the internal write sequencer on clk_i.
*/
`timescale 1ns/100ps
`include "flash_front_end_consts.svh"
module serial_flash_bus_front_end #(
  parameter int DUMMY_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic por_active_i,
  input wire logic quad_enable_i,
  input wire logic write_busy_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] data_line_i,
  output logic [3:0] data_line_o,
  output logic [3:0] data_line_oe_o,
  output logic [7:0] rd_data_i_unused_o,
  input wire logic [7:0] rd_data_i,
  output logic [23:0] addr_o,
  output logic [11:0] sector_o,
  output logic [8:0] half_block_o,
  output logic [7:0] block_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_o,
  output logic four_line_instruction_mode_o,
  output logic standby_o,
  output logic paused_o,
  output logic write_guard_n_o
);
  typedef struct packed {
    logic [1:0] sclk_s1;
    logic [1:0] sclk_s2;
    logic cs_s1;
    logic cs_s2;
    logic [3:0] dl_s1;
    logic [3:0] dl_s2;
    logic sclk_last;
    logic cs_last;
    logic armed;
    logic four_line;
    logic reset_armed;
    logic paused;
    flash_front_end_pkg::phase_type phase;
    flash_front_end_pkg::width_type in_w;
    flash_front_end_pkg::width_type out_w;
    logic reads;
    logic [7:0] shift;
    logic [3:0] bits;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [4:0] cnt;
    logic [7:0] out_byte;
    logic [3:0] dout;
    logic [3:0] doe;
    logic cmd_valid;
    logic standby;
  } state_type;

  state_type q, d;
  logic rise, fall, sclk_lvl, cs_lvl, cs_fall, pause_in, hold_ok;
  logic [3:0] din;
  logic [7:0] nxt;
  logic [3:0] step;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.sclk_s1 = {1'b0, sclk_i};
    d.sclk_s2 = q.sclk_s1;
    d.cs_s1 = cs_n_i;
    d.cs_s2 = q.cs_s1;
    d.dl_s1 = data_line_i;
    d.dl_s2 = q.dl_s1;
    sclk_lvl = q.sclk_s2[0];
    cs_lvl = q.cs_s2;
    din = q.dl_s2;
    d.sclk_last = sclk_lvl;
    d.cs_last = cs_lvl;
    rise = sclk_lvl & ~q.sclk_last;
    fall = ~sclk_lvl & q.sclk_last;
    cs_fall = q.cs_last & ~cs_lvl;
    // Pause pin only counts outside quad use
    hold_ok = ~quad_enable_i & ~q.four_line;
    pause_in = hold_ok & ~din[3];
    d.cmd_valid = 1'b0;
    nxt = q.shift;
    step = 4'h1;
    unique case (q.in_w)
      flash_front_end_pkg::W_ONE: begin
        nxt = {q.shift[6:0], din[0]};
        step = 4'h1;
      end
      flash_front_end_pkg::W_TWO: begin
        nxt = {q.shift[5:0], din[1:0]};
        step = 4'h2;
      end
      flash_front_end_pkg::W_FOUR: begin
        nxt = {q.shift[3:0], din};
        step = 4'h4;
      end
      default: begin
        nxt = q.shift;
        step = 4'h1;
      end
    endcase
    // Standby waits for the internal write to finish
    d.standby = cs_lvl & ~write_busy_i;
    if (cs_fall) begin
      d.armed = 1'b1;
    end
    // Clock level gating: entry and exit only with clock low
    if (~cs_lvl & ~sclk_lvl) begin
      d.paused = pause_in;
    end
    if (cs_lvl | por_active_i) begin
      // Deselect, or deselect during pause, drops the transfer
      d.paused = 1'b0;
      d.phase = flash_front_end_pkg::PH_CMD;
      d.bits = 4'h0;
      d.shift = 8'h00;
      d.doe = 4'h0;
      d.in_w = q.four_line ? flash_front_end_pkg::W_FOUR : flash_front_end_pkg::W_ONE;
      d.reads = 1'b0;
    end else if (q.paused | ~q.armed) begin
      d.doe = q.paused ? 4'h0 : q.doe;
    end else if (rise && q.phase != flash_front_end_pkg::PH_DATA) begin
      d.shift = nxt;
      d.bits = q.bits + step;
      if (q.phase == flash_front_end_pkg::PH_CMD && (q.bits + step) == 4'h8) begin
        d.bits = 4'h0;
        d.cmd = nxt;
        d.cmd_valid = 1'b1;
        d.phase = flash_front_end_pkg::PH_IDLE;
        d.reads = 1'b0;
        d.out_w = q.four_line ? flash_front_end_pkg::W_FOUR : flash_front_end_pkg::W_ONE;
        unique case (nxt)
          `CMD_DUAL_OUT: begin
            d.reads = 1'b1;
            d.out_w = flash_front_end_pkg::W_TWO;
            d.phase = flash_front_end_pkg::PH_ADDR;
          end
          `CMD_DUAL_IO: begin
            d.reads = 1'b1;
            d.out_w = flash_front_end_pkg::W_TWO;
            d.in_w = flash_front_end_pkg::W_TWO;
            d.phase = flash_front_end_pkg::PH_ADDR;
          end
          `CMD_QUAD_OUT, `CMD_QUAD_IO, `CMD_QUAD_WORD, `CMD_QUAD_OCTAL: begin
            if (quad_enable_i) begin
              d.reads = 1'b1;
              d.out_w = flash_front_end_pkg::W_FOUR;
              if (nxt != `CMD_QUAD_OUT) begin
                d.in_w = flash_front_end_pkg::W_FOUR;
              end
              d.phase = flash_front_end_pkg::PH_ADDR;
            end
          end
          `CMD_ENTER_4L: begin
            if (quad_enable_i) begin
              d.four_line = 1'b1;
            end
          end
          `CMD_EXIT_4L: begin
            d.four_line = 1'b0;
          end
          `CMD_RESET_EN: begin
            d.reset_armed = 1'b1;
          end
          `CMD_RESET: begin
            if (q.reset_armed) begin
              d.four_line = 1'b0;
            end
          end
          default: begin
            d.phase = flash_front_end_pkg::PH_IDLE;
          end
        endcase
        if (nxt != `CMD_RESET_EN) begin
          d.reset_armed = 1'b0;
        end
        d.cnt = 5'h0;
      end else if (q.phase == flash_front_end_pkg::PH_ADDR && (q.bits + step) == 4'h8) begin
        d.bits = 4'h0;
        d.addr = {q.addr[15:0], nxt};
        d.cnt = q.cnt + 5'h1;
        if (q.cnt == 5'h2) begin
          d.phase = flash_front_end_pkg::PH_DUMMY;
          d.cnt = 5'h0;
        end
      end else if (q.phase == flash_front_end_pkg::PH_DUMMY) begin
        d.bits = 4'h0;
        d.cnt = q.cnt + 5'h1;
        if (q.cnt == 5'(DUMMY_CYCLES - 1)) begin
          d.phase = flash_front_end_pkg::PH_DATA;
          d.out_byte = rd_data_i;
          d.bits = 4'h0;
        end
      end
    end else if (fall && q.phase == flash_front_end_pkg::PH_DATA) begin
      // Output moves only after falling edges, MSB first
      unique case (q.out_w)
        flash_front_end_pkg::W_ONE: begin
          d.dout = {2'b00, q.out_byte[7], 1'b0};
          d.doe = 4'b0010;
          d.out_byte = {q.out_byte[6:0], 1'b0};
          d.bits = q.bits + 4'h1;
        end
        flash_front_end_pkg::W_TWO: begin
          d.dout = {2'b00, q.out_byte[7:6]};
          d.doe = 4'b0011;
          d.out_byte = {q.out_byte[5:0], 2'b00};
          d.bits = q.bits + 4'h2;
        end
        default: begin
          d.dout = q.out_byte[7:4];
          d.doe = 4'b1111;
          d.out_byte = {q.out_byte[3:0], 4'h0};
          d.bits = q.bits + 4'h4;
        end
      endcase
      if (d.bits == 4'h8) begin
        d.bits = 4'h0;
        d.addr = q.addr + 24'h000001;
        d.out_byte = rd_data_i;
      end
    end
    if (por_active_i) begin
      d.armed = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.sclk_last <= 1'b0;
      // Synchronisers start low: a select held low never looks like a fall
      q.cs_s1 <= 1'b0;
      q.cs_s2 <= 1'b0;
      q.cs_last <= 1'b0;
      q.standby <= 1'b1;
      q.in_w <= flash_front_end_pkg::W_ONE;
      q.out_w <= flash_front_end_pkg::W_ONE;
      q.phase <= flash_front_end_pkg::PH_CMD;
    end else begin
      q <= d;
    end
  end

  assign data_line_o = q.dout;
  assign data_line_oe_o = q.doe;
  assign rd_data_i_unused_o = q.out_byte;
  assign addr_o = q.addr;
  assign sector_o = q.addr[`ADDR_BITS-1:`SECTOR_LSB];
  assign half_block_o = q.addr[`ADDR_BITS-1:`HALF_BLOCK_LSB];
  assign block_o = q.addr[`ADDR_BITS-1:`BLOCK_LSB];
  assign cmd_valid_o = q.cmd_valid;
  assign cmd_o = q.cmd;
  assign four_line_instruction_mode_o = q.four_line;
  assign standby_o = q.standby;
  assign paused_o = q.paused;
  assign write_guard_n_o = quad_enable_i | q.dl_s2[2];

  ////////////////////////////////////////////////////////////////////////////
  AST_DESEL_RELEASE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.cs_s2 |=> q.doe == 4'h0) else $error("lines driven while deselected");
  AST_PAUSE_RELEASE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.paused |=> q.doe == 4'h0) else $error("lines driven while paused");
  AST_PAUSE_CLK_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(q.paused) |-> $past(~q.sclk_s2[0])) else $error("pause began with clock high");
  AST_UNPAUSE_CLK_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(q.paused) && !$past(q.cs_s2) |-> $past(~q.sclk_s2[0]))
    else $error("pause ended with clock high");
  AST_DESEL_PAUSE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.paused && q.cs_s2 |=> !q.paused && q.phase == flash_front_end_pkg::PH_CMD)
    else $error("pause survived deselect");
  AST_4L_NEEDS_QE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(q.four_line) |-> $past(quad_enable_i)) else $error("four-line without enable");
  AST_STANDBY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !q.cs_s2 |=> !q.standby) else $error("standby while selected");
  AST_BUSY_NO_STANDBY: assert property (@(posedge clk_i) disable iff (!rstn_i)
    write_busy_i |=> !q.standby) else $error("standby during write");
  AST_POR_IGNORE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    por_active_i |=> !q.cmd_valid) else $error("command during power-on reset");
  AST_QUAD_OE: assert property (@(posedge clk_i) disable iff (!rstn_i)
    q.doe == 4'hF |-> quad_enable_i || q.four_line) else $error("quad drive without enable");
  COV_PAUSE: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(q.paused));
  COV_4L: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(q.four_line));
  COV_READ: cover property (@(posedge clk_i) disable iff (!rstn_i)
    q.phase == flash_front_end_pkg::PH_DATA && q.doe != 4'h0);
endmodule : serial_flash_bus_front_end

/* tb/host_spi_model.sv */
/* Host serial controller model, clock mode 0, four data lines.
   Assumes tasks are entered just after a rising clk_i edge. */
`timescale 1ns/100ps
module host_spi_model (
  input wire logic clk_i,
  input wire logic [3:0] wire_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] line_o,
  output logic [3:0] line_oe_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    line_o = 4'hF;
    line_oe_o = 4'h0;
  end
  ////////////////////////////////////////
  // One period of 12 clk; lines sampled just before the rise
  task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
    line_o <= v;
    line_oe_o <= oe;
    repeat (6) @(posedge clk_i);
    got = wire_i;
    sclk_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    sclk_o <= 1'b0;
  endtask : tick
  task automatic send(input logic [7:0] b, input logic quad);
    logic [3:0] g;
    if (quad) begin
      tick(b[7:4], 4'hF, g);
      tick(b[3:0], 4'hF, g);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        tick({3'h0, b[i]}, 4'h1, g);
      end
    end
  endtask : send
  task automatic sel();
    cs_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : sel
  task automatic desel();
    repeat (6) @(posedge clk_i);
    cs_n_o <= 1'b1;
    line_oe_o <= 4'h0;
    repeat (12) @(posedge clk_i);
  endtask : desel
  task automatic frame(input logic [7:0] b, input logic quad);
    sel();
    send(b, quad);
    desel();
  endtask : frame
endmodule : host_spi_model

/* tb/tb.sv */
/* Self-checking bench for the flash front end with a host model.
   Assumes two dummy clocks and a constant array byte. */
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic por_active_i = 1'b0;
  logic quad_enable_i = 1'b0;
  logic write_busy_i = 1'b0;
  logic [7:0] rd_data_i = 8'hC6;
  logic tog = 1'b0;
  logic sclk, cs_n, cmd_valid_o, mode_o, standby_o, paused_o, wg_n;
  logic [3:0] h_o, h_oe, d_o, d_oe, bus;
  logic [23:0] addr_o;
  logic [11:0] sector_o;
  logic [8:0] half_block_o;
  logic [7:0] block_o, cmd_o, last_cmd;
  int n_errors = 0;
  int n_compared = 0;
  int n_cmd = 0;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  // Released lines: pull-ups on 2 and 3, a toggling level on 0 and 1
  assign bus = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & {2'b11, tog, tog});
  host_spi_model i_host_spi_model (.clk_i(clk_i), .wire_i(bus), .sclk_o(sclk),
    .cs_n_o(cs_n), .line_o(h_o), .line_oe_o(h_oe));
  serial_flash_bus_front_end #(.DUMMY_CYCLES(2)) i_serial_flash_bus_front_end (
    .clk_i(clk_i), .rstn_i(rstn_i), .por_active_i(por_active_i),
    .quad_enable_i(quad_enable_i), .write_busy_i(write_busy_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .data_line_i(bus), .data_line_o(d_o), .data_line_oe_o(d_oe),
    .rd_data_i_unused_o(), .rd_data_i(rd_data_i), .addr_o(addr_o),
    .sector_o(sector_o), .half_block_o(half_block_o), .block_o(block_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .four_line_instruction_mode_o(mode_o),
    .standby_o(standby_o), .paused_o(paused_o), .write_guard_n_o(wg_n));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    tog <= ~tog;
    cycles <= cycles + 1;
    if (cmd_valid_o === 1'b1) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= cmd_o;
    end
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  ////////////////////////////////////////
  task automatic t_por();
    por_active_i <= 1'b1;
    i_host_spi_model.frame(8'h66, 1'b0);
    por_active_i <= 1'b0;
    chk(n_cmd, 0);
  endtask : t_por
  task automatic t_cmd();
    i_host_spi_model.sel();
    chk(standby_o, 0);
    i_host_spi_model.send(8'h66, 1'b0);
    i_host_spi_model.desel();
    chk({n_cmd[15:0], last_cmd}, 24'h000166);
    chk(standby_o, 1);
    write_busy_i <= 1'b1;
    i_host_spi_model.frame(8'h99, 1'b0);
    chk(standby_o, 0);
    write_busy_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(standby_o, 1);
  endtask : t_cmd
  task automatic t_mode();
    i_host_spi_model.frame(8'h38, 1'b0);
    chk(mode_o, 0);
    quad_enable_i <= 1'b1;
    i_host_spi_model.frame(8'h38, 1'b0);
    chk(mode_o, 1);
    i_host_spi_model.frame(8'h66, 1'b1);
    i_host_spi_model.frame(8'h99, 1'b1);
    chk({n_cmd[15:0], last_cmd}, 24'h000699);
    chk(mode_o, 0);
  endtask : t_mode
  task automatic t_read();
    logic [3:0] g1;
    logic [3:0] g2;
    i_host_spi_model.sel();
    i_host_spi_model.send(8'h6B, 1'b0);
    i_host_spi_model.send(8'hFE, 1'b0);
    i_host_spi_model.send(8'h81, 1'b0);
    i_host_spi_model.send(8'h23, 1'b0);
    repeat (2) i_host_spi_model.tick(4'h0, 4'h0, g1);
    chk(addr_o, 24'hFE8123);
    chk({sector_o, half_block_o[2:0], block_o, 1'b0}, {12'hFE8, 3'h5, 8'hFE, 1'b0});
    i_host_spi_model.tick(4'h0, 4'h0, g1);
    i_host_spi_model.tick(4'h0, 4'h0, g2);
    chk({g1, g2}, 24'h0000C6);
    chk(d_oe, 4'hF);
    chk(wg_n, 1);
    i_host_spi_model.desel();
    chk(d_oe, 4'h0);
  endtask : t_read
  task automatic t_pause();
    logic [3:0] g;
    quad_enable_i <= 1'b0;
    i_host_spi_model.sel();
    for (int i = 7; i >= 0; i--) begin
      if (i == 3) begin
        i_host_spi_model.tick(4'h1, 4'h9, g);
        chk({paused_o, d_oe}, 5'h10);
      end
      i_host_spi_model.tick({3'h4, 1'(8'h66 >> i)}, 4'h9, g);
    end
    chk(paused_o, 0);
    i_host_spi_model.tick(4'h0, 4'h9, g);
    i_host_spi_model.desel();
    i_host_spi_model.frame(8'h99, 1'b0);
    chk({n_cmd[15:0], last_cmd}, 24'h000999);
  endtask : t_pause
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_por();
    t_cmd();
    t_mode();
    t_read();
    t_pause();
    stop_test();
  end
endmodule : tb
